// [src/sesb_axil_slave.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sesb_consts.svh"

module sesb_axil_slave
  import sesb_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  // write address and data
  input  wire logic [`SESB_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // read
  input  wire logic [`SESB_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // register side
  output sesb_regreq_t                 req,
  input  wire logic [1:0]              wrResp,
  input  wire logic [31:0]             rdData,
  input  wire logic [1:0]              rdResp
);

  logic [`SESB_ADDR_W-1:0] awAddr;
  logic [31:0]             wData;
  logic [3:0]              wStrb;
  logic                    doWrite;

  // both halves held and no response pending
  assign doWrite = !awready && !wready && !bvalid;

  assign req.wrEn   = doWrite;
  assign req.wrAddr = awAddr;
  assign req.wrData = wData;
  assign req.wrStrb = wStrb;
  assign req.rdAddr = araddr;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `SESB_RESP_OKAY;
      awAddr  <= '0;
      wData   <= '0;
      wStrb   <= '0;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        awAddr  <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wData  <= wdata;
        wStrb  <= wstrb;
        wready <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= wrResp;
      end
      else if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `SESB_RESP_OKAY;
    end
    else if (ce)
    begin
      if (arvalid && arready)
      begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rdata   <= rdData;
        rresp   <= rdResp;
      end
      else if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : sesb_axil_slave
`default_nettype wire

// [src/sesb_consts.svh]
`ifndef SESB_CONSTS_SVH
`define SESB_CONSTS_SVH

// register map
`define SESB_ADDR_W        12
`define SESB_ISR_OFF       12'h10c
`define SESB_SECSTAT_OFF   12'h114

// bus responses
`define SESB_RESP_OKAY     2'h0
`define SESB_RESP_DECERR   2'h3

// detail flags occupy status bits 26..7
`define SESB_FLAG_LSB      7
`define SESB_FLAG_W        20
`define SESB_FLAG_RST      20'h10000
`define SESB_FLAG_LEVEL    20'h20000

// flag vector index ranges (status bit minus 7)
`define SESB_F_SEQ0_MSB    19
`define SESB_F_SEQ0_LSB    18
`define SESB_F_SEQ0_LIVE   17
`define SESB_F_XBUS_MSB    16
`define SESB_F_XBUS_LSB    15
`define SESB_F_TWI_MSB     14
`define SESB_F_TWI_LSB     10
`define SESB_F_VPROT_MSB   9
`define SESB_F_VPROT_LSB   7
`define SESB_F_VFIFO_MSB   6
`define SESB_F_VFIFO_LSB   4
`define SESB_F_AFIFO_MSB   3
`define SESB_F_AFIFO_LSB   0

// summary bits of the interrupt status word
`define SESB_SUM_SEQ0      23
`define SESB_SUM_XBUS      18
`define SESB_SUM_TWI       16
`define SESB_SUM_AFIFO     11
`define SESB_SUM_VPROT     10
`define SESB_SUM_VFIFO     9
`define SESB_SUM_XBUS_RST  1'h1

`endif

// [src/sesb_flag_bank.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sesb_consts.svh"

module sesb_flag_bank
  import sesb_pkg::*;
(
  // clock and reset
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  // per flag set and clear
  input  wire logic [`SESB_FLAG_W-1:0] set,
  input  wire logic [`SESB_FLAG_W-1:0] clr,
  // flag state
  output logic      [`SESB_FLAG_W-1:0] flags
);

  localparam logic [`SESB_FLAG_W-1:0] RstVal = `SESB_FLAG_RST;
  localparam logic [`SESB_FLAG_W-1:0] Level  = `SESB_FLAG_LEVEL;

  genvar i;
  generate
    for (i = 0; i < `SESB_FLAG_W; i++)
    begin : g_flag
      always_ff @(posedge ref_clk)
      begin
        if (!rst_b)
          flags[i] <= RstVal[i];
        else if (ce)
        begin
          if (Level[i])
            flags[i] <= set[i];
          else if (set[i])
            flags[i] <= 1'b1;
          else if (clr[i])
            flags[i] <= 1'b0;
        end
      end
    end
  endgenerate

  chk_set_wins: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ce |=> ((flags & $past(set & ~Level)) == $past(set & ~Level)))
    else $error("sticky flag lost its set event");

  chk_clear_acts: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ce |=> ((flags & $past(clr & ~set & ~Level)) == '0))
    else $error("flag survived its clear");

endmodule : sesb_flag_bank
`default_nettype wire

// [src/sesb_pkg.sv]
package sesb_pkg;

  // event and state inputs from the source units, all on ref_clk
  typedef struct packed {
    logic       seq0RegErr;
    logic       seq0PageErr;
    logic       seq0Run;
    logic       seq0Wait;
    logic       seq0Upload;
    logic       seq0Restart;
    logic       xbusTimeout;
    logic       xbusFormat;
    logic       twiAddrNack;
    logic       twiWriteNack;
    logic       twiReadNack;
    logic       twiArbLost;
    logic       twiFrame;
    logic       twiCmdStart;
    logic [2:0] vdmaProt;
    logic [2:0] vdmaReload;
    logic [2:0] vfifoFlow;
    logic [3:0] afifoErr;
    logic [3:0] afifoRestart;
  } sesb_src_t;

  // summary bits of the interrupt status word
  typedef struct packed {
    logic seq0;
    logic xbus;
    logic twi;
    logic afifo;
    logic vprot;
    logic vfifo;
  } sesb_sum_t;

  // register access from the bus slave
  typedef struct packed {
    logic        wrEn;
    logic [11:0] wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
    logic [11:0] rdAddr;
  } sesb_regreq_t;

endpackage : sesb_pkg

// [src/sesb_top.sv]
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "sesb_consts.svh"

module sesb_top
  import sesb_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic                    ce,
  // source unit events
  input  wire sesb_src_t               src,
  // axi4-lite write
  input  wire logic [`SESB_ADDR_W-1:0] awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read
  input  wire logic [`SESB_ADDR_W-1:0] araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // state seen by the rest of the chip
  output logic [`SESB_FLAG_W-1:0]      statusFlags,
  output sesb_sum_t                    isrSummary
);

  localparam logic [`SESB_FLAG_W-1:0] Level = `SESB_FLAG_LEVEL;

  sesb_regreq_t             req;
  logic [1:0]               wrResp;
  logic [31:0]              rdData;
  logic [1:0]               rdResp;
  logic [31:0]              strbMask;
  logic [31:0]              isrClr;
  logic [`SESB_FLAG_W-1:0]  setVec;
  logic [`SESB_FLAG_W-1:0]  clrVec;
  logic                     seq0Live;
  logic                     seq0Clr;
  logic                     xbusClr;
  logic                     twiClr;
  logic [31:0]              isrWord;
  sesb_sum_t                next_sum;

  sesb_axil_slave u_slave (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .req     (req),
    .wrResp  (wrResp),
    .rdData  (rdData),
    .rdResp  (rdResp)
  );

  // write-one-to-clear on the summary word, byte lanes honoured
  assign strbMask = {{8{req.wrStrb[3]}}, {8{req.wrStrb[2]}},
                     {8{req.wrStrb[1]}}, {8{req.wrStrb[0]}}};
  assign isrClr   = (req.wrEn && req.wrAddr == `SESB_ISR_OFF)
                    ? (req.wrData & strbMask) : 32'h0;

  // the status word is accepted with okay but changes nothing
  assign wrResp = (req.wrAddr == `SESB_ISR_OFF ||
                   req.wrAddr == `SESB_SECSTAT_OFF)
                  ? `SESB_RESP_OKAY : `SESB_RESP_DECERR;

  assign seq0Live = src.seq0Run && !src.seq0Wait && !src.seq0Upload;
  assign seq0Clr  = isrClr[`SESB_SUM_SEQ0] || src.seq0Restart;
  assign xbusClr  = isrClr[`SESB_SUM_XBUS];
  assign twiClr   = isrClr[`SESB_SUM_TWI] || src.twiCmdStart;

  // set vector in status bit order 26 down to 7
  assign setVec = {src.seq0RegErr,
                   src.seq0PageErr,
                   seq0Live,
                   src.xbusTimeout,
                   src.xbusFormat,
                   src.twiAddrNack,
                   src.twiWriteNack,
                   src.twiReadNack,
                   src.twiArbLost,
                   src.twiFrame,
                   src.vdmaProt,
                   src.vfifoFlow,
                   src.afifoErr[3],
                   src.afifoErr[2],
                   src.afifoErr[1],
                   src.afifoErr[0]};

  assign clrVec = {{2{seq0Clr}},
                   1'b0,
                   {2{xbusClr}},
                   {5{twiClr}},
                   src.vdmaReload | {3{isrClr[`SESB_SUM_VPROT]}},
                   src.vdmaReload | {3{isrClr[`SESB_SUM_VFIFO]}},
                   src.afifoRestart | {4{isrClr[`SESB_SUM_AFIFO]}}};

  sesb_flag_bank u_flags (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .set     (setVec),
    .clr     (clrVec),
    .flags   (statusFlags)
  );

  // summary bits track the detail flags one cycle later
  always_comb
  begin
    next_sum.seq0  = |statusFlags[`SESB_F_SEQ0_MSB:`SESB_F_SEQ0_LSB];
    next_sum.xbus  = |statusFlags[`SESB_F_XBUS_MSB:`SESB_F_XBUS_LSB];
    next_sum.twi   = |statusFlags[`SESB_F_TWI_MSB:`SESB_F_TWI_LSB];
    next_sum.afifo = |statusFlags[`SESB_F_AFIFO_MSB:`SESB_F_AFIFO_LSB];
    next_sum.vprot = |statusFlags[`SESB_F_VPROT_MSB:`SESB_F_VPROT_LSB];
    next_sum.vfifo = |statusFlags[`SESB_F_VFIFO_MSB:`SESB_F_VFIFO_LSB];
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      isrSummary      <= '0;
      isrSummary.xbus <= `SESB_SUM_XBUS_RST;
    end
    else if (ce)
      isrSummary <= next_sum;
  end

  // read decode
  always_comb
  begin
    isrWord                 = 32'h0;
    isrWord[`SESB_SUM_SEQ0]  = isrSummary.seq0;
    isrWord[`SESB_SUM_XBUS]  = isrSummary.xbus;
    isrWord[`SESB_SUM_TWI]   = isrSummary.twi;
    isrWord[`SESB_SUM_AFIFO] = isrSummary.afifo;
    isrWord[`SESB_SUM_VPROT] = isrSummary.vprot;
    isrWord[`SESB_SUM_VFIFO] = isrSummary.vfifo;
    rdResp                  = `SESB_RESP_OKAY;
    case (req.rdAddr)
      `SESB_ISR_OFF:     rdData = isrWord;
      `SESB_SECSTAT_OFF: rdData = {5'h0, statusFlags, 7'h0};
      default:
      begin
        rdData = 32'h0;
        rdResp = `SESB_RESP_DECERR;
      end
    endcase
  end

  sequence xbusClearWrite;
    ce && isrClr[`SESB_SUM_XBUS] && !src.xbusTimeout && !src.xbusFormat;
  endsequence

  sequence xbusQuiet;
    ce && !src.xbusTimeout && !src.xbusFormat;
  endsequence

  chk_seq0_errors: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.seq0RegErr) |=> statusFlags[`SESB_F_SEQ0_MSB])
    else $error("seq0 register access error not flagged");

  chk_seq0_live: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ce |=> statusFlags[`SESB_F_SEQ0_LIVE] ==
           $past(src.seq0Run && !src.seq0Wait && !src.seq0Upload))
    else $error("seq0 active bit wrong");

  chk_xbus_reset: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> statusFlags[`SESB_F_XBUS_MSB] && isrSummary.xbus)
    else $error("xbus timeout flag not high after reset");

  chk_xbus_sticky: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && statusFlags[`SESB_F_XBUS_LSB] && !xbusClr)
      |=> statusFlags[`SESB_F_XBUS_LSB])
    else $error("xbus format flag dropped without clear");

  chk_twi_restart: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.twiCmdStart &&
     setVec[`SESB_F_TWI_MSB:`SESB_F_TWI_LSB] == 5'h0)
      |=> statusFlags[`SESB_F_TWI_MSB:`SESB_F_TWI_LSB] == 5'h0)
    else $error("twi flags not cleared by new command");

  chk_vprot_set: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.vdmaProt[2]) |=> statusFlags[`SESB_F_VPROT_MSB])
    else $error("video dma 3 protection error not flagged");

  chk_afifo_restart: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.afifoRestart[0] && !src.afifoErr[0])
      |=> !statusFlags[`SESB_F_AFIFO_LSB])
    else $error("audio fifo flag not cleared by restart");

  chk_xbus_summary: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    xbusClearWrite ##1 xbusQuiet |=> !isrSummary.xbus)
    else $error("xbus summary did not clear after write");

  chk_twi_summary: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.twiArbLost) ##1 ce |=> isrSummary.twi)
    else $error("twi summary not raised");

  chk_vprot_summary: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ce |=> isrSummary.vprot ==
           $past(|statusFlags[`SESB_F_VPROT_MSB:`SESB_F_VPROT_LSB]))
    else $error("video protection summary wrong");

  chk_vfifo_summary: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    ce |=> isrSummary.vfifo ==
           $past(|statusFlags[`SESB_F_VFIFO_MSB:`SESB_F_VFIFO_LSB]))
    else $error("video fifo summary wrong");

  chk_status_ro: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && req.wrEn && req.wrAddr == `SESB_SECSTAT_OFF &&
     setVec == '0 && clrVec == '0)
      |=> (statusFlags & ~Level) == $past(statusFlags & ~Level))
    else $error("write changed the status word");

  chk_seq0_page: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.seq0PageErr) |=> statusFlags[`SESB_F_SEQ0_LSB])
    else $error("seq0 page error not flagged");

  chk_ain2_set: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    (ce && src.afifoErr[3]) |=> statusFlags[`SESB_F_AFIFO_MSB])
    else $error("audio input fifo 2 underflow not flagged");

  // a low enable must hold every flag and summary bit
  chk_ce_freeze: assert property (
    @(posedge ref_clk) disable iff (!rst_b)
    !ce |=> $stable(statusFlags) && $stable(isrSummary))
    else $error("state moved while clock enable low");

endmodule : sesb_top
`default_nettype wire

// [test/sesb_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sesb_consts.svh"

module sesb_top_bench
  import sesb_pkg::*;
;
  logic                    ref_clk = 1'h0;
  logic                    rst_b   = 1'h0;
  logic                    ce      = 1'h1;
  sesb_src_t               src     = '0;
  sesb_src_t               lvl     = '0;
  logic [`SESB_ADDR_W-1:0] awaddr  = 12'h000;
  logic                    awvalid = 1'h0;
  logic                    awready;
  logic [31:0]             wdata   = 32'h0;
  logic [3:0]              wstrb   = 4'h0;
  logic                    wvalid  = 1'h0;
  logic                    wready;
  logic [1:0]              bresp;
  logic                    bvalid;
  logic                    bready  = 1'h0;
  logic [`SESB_ADDR_W-1:0] araddr  = 12'h000;
  logic                    arvalid = 1'h0;
  logic                    arready;
  logic [31:0]             rdata;
  logic [1:0]              rresp;
  logic                    rvalid;
  logic                    rready  = 1'h0;
  logic [19:0]             statusFlags;
  sesb_sum_t               isrSummary;
  logic [19:0]             expFlags;
  int                      errTotal = 0;
  int                      nTests   = 0;

  always #2.5 ref_clk = ~ref_clk;

  sesb_top u_dut (
    .ref_clk     (ref_clk),
    .rst_b       (rst_b),
    .ce          (ce),
    .src         (src),
    .awaddr      (awaddr),
    .awvalid     (awvalid),
    .awready     (awready),
    .wdata       (wdata),
    .wstrb       (wstrb),
    .wvalid      (wvalid),
    .wready      (wready),
    .bresp       (bresp),
    .bvalid      (bvalid),
    .bready      (bready),
    .araddr      (araddr),
    .arvalid     (arvalid),
    .arready     (arready),
    .rdata       (rdata),
    .rresp       (rresp),
    .rvalid      (rvalid),
    .rready      (rready),
    .statusFlags (statusFlags),
    .isrSummary  (isrSummary)
  );

  task automatic endOfTest();
    $display("tests %0d errors %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : endOfTest

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    output logic [1:0] resp);
    logic awDone;
    logic wDone;
    awDone = 1'h0;
    wDone  = 1'h0;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    while (!(awDone && wDone))
    begin
      @(posedge ref_clk);
      if (awvalid && awready)
      begin
        awDone = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready)
      begin
        wDone = 1'h1;
        wvalid <= 1'h0;
      end
    end
    bready <= 1'h1;
    do @(posedge ref_clk); while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    araddr  <= a;
    arvalid <= 1'h1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'h0;
    rready  <= 1'h1;
    do @(posedge ref_clk); while (!rvalid);
    d    = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask : rd

  // one source event per flag index; index 17 is the live bit
  function automatic sesb_src_t evOf(input int k);
    sesb_src_t e;
    e = '0;
    if (k < 4)
      e.afifoErr[k] = 1'h1;
    else if (k < 7)
      e.vfifoFlow[k-4] = 1'h1;
    else if (k < 10)
      e.vdmaProt[k-7] = 1'h1;
    else
      case (k)
        10: e.twiFrame = 1'h1;
        11: e.twiArbLost = 1'h1;
        12: e.twiReadNack = 1'h1;
        13: e.twiWriteNack = 1'h1;
        14: e.twiAddrNack = 1'h1;
        15: e.xbusFormat = 1'h1;
        16: e.xbusTimeout = 1'h1;
        18: e.seq0PageErr = 1'h1;
        default: e.seq0RegErr = 1'h1;
      endcase
    return e;
  endfunction : evOf

  function automatic sesb_sum_t sumOf(input logic [19:0] f);
    sesb_sum_t s;
    s.seq0  = |f[19:18];
    s.xbus  = |f[16:15];
    s.twi   = |f[14:10];
    s.afifo = |f[3:0];
    s.vprot = |f[9:7];
    s.vfifo = |f[6:4];
    return s;
  endfunction : sumOf

  task automatic pulse(input sesb_src_t m);
    @(posedge ref_clk);
    src <= m | lvl;
    @(posedge ref_clk);
    src <= lvl;
  endtask : pulse

  task automatic look();
    logic [31:0] d;
    logic [1:0]  r;
    logic [31:0] e;
    sesb_sum_t   s;
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(statusFlags), 32'(expFlags));
    chk(32'(isrSummary), 32'(sumOf(expFlags)));
    // bus requests start on a clock edge
    @(posedge ref_clk);
    rd(`SESB_SECSTAT_OFF, d, r);
    chk(32'(d[26:7]), 32'(expFlags));
    chk(32'(r), 32'(`SESB_RESP_OKAY));
    s = sumOf(expFlags);
    e = 32'h0;
    e[`SESB_SUM_SEQ0]  = s.seq0;
    e[`SESB_SUM_XBUS]  = s.xbus;
    e[`SESB_SUM_TWI]   = s.twi;
    e[`SESB_SUM_AFIFO] = s.afifo;
    e[`SESB_SUM_VPROT] = s.vprot;
    e[`SESB_SUM_VFIFO] = s.vfifo;
    rd(`SESB_ISR_OFF, d, r);
    chk(d, e);
    chk(32'(r), 32'(`SESB_RESP_OKAY));
  endtask : look

  task automatic liveStep(input logic run, input logic wt, input logic up,
                          input logic exp);
    lvl.seq0Run    = run;
    lvl.seq0Wait   = wt;
    lvl.seq0Upload = up;
    @(posedge ref_clk);
    src <= lvl;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(32'(statusFlags[17]), 32'(exp));
  endtask : liveStep

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    errTotal++;
    endOfTest();
  end

  initial
  begin
    logic [31:0] d;
    logic [1:0]  r;
    sesb_src_t   c;
    static int          sumBit [6] = '{23, 18, 16, 11, 10, 9};
    static logic [19:0] grp [6] = '{20'hc0000, 20'h18000, 20'h07c00,
                             20'h0000f, 20'h00380, 20'h00070};
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'h1;
    expFlags = 20'h10000;
    look();
    wr(`SESB_ISR_OFF, 32'h1 << 18, r);
    expFlags = 20'h0;
    look();
    c = '0;
    for (int k = 0; k < 20; k++)
    begin
      if (k == 17)
        continue;
      pulse(evOf(k));
      c = c | evOf(k);
      expFlags[k] = 1'h1;
      look();
    end
    wr(`SESB_SECSTAT_OFF, 32'hffffffff, r);
    chk(32'(r), 32'(`SESB_RESP_OKAY));
    look();
    wr(12'h200, 32'hffffffff, r);
    chk(32'(r), 32'(`SESB_RESP_DECERR));
    rd(12'h200, d, r);
    chk(32'(r), 32'(`SESB_RESP_DECERR));
    chk(d, 32'h0);
    for (int g = 0; g < 6; g++)
    begin
      wr(`SESB_ISR_OFF, 32'h1 << sumBit[g], r);
      expFlags = expFlags & ~grp[g];
      look();
    end
    pulse(c);
    expFlags = 20'hdffff;
    look();
    c = '0;
    c.seq0Restart = 1'h1;
    pulse(c);
    expFlags[19:18] = 2'h0;
    look();
    c = '0;
    c.twiCmdStart = 1'h1;
    pulse(c);
    expFlags[14:10] = 5'h0;
    look();
    for (int i = 0; i < 3; i++)
    begin
      c = '0;
      c.vdmaReload[i] = 1'h1;
      pulse(c);
      expFlags[7+i] = 1'h0;
      expFlags[4+i] = 1'h0;
      look();
    end
    for (int i = 0; i < 4; i++)
    begin
      c = '0;
      c.afifoRestart[i] = 1'h1;
      pulse(c);
      expFlags[i] = 1'h0;
      look();
    end
    // event and clear in the same cycle: the event must survive
    c = evOf(14);
    c.twiCmdStart = 1'h1;
    pulse(c);
    expFlags[14] = 1'h1;
    look();
    c = evOf(0);
    c.afifoRestart[0] = 1'h1;
    pulse(c);
    expFlags[0] = 1'h1;
    look();
    // enable low: the pulse is lost and nothing moves, bus kept idle
    ce <= 1'h0;
    pulse(evOf(13));
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(statusFlags), 32'(expFlags));
    chk(32'(isrSummary), 32'(sumOf(expFlags)));
    @(posedge ref_clk);
    ce <= 1'h1;
    look();
    liveStep(1'h1, 1'h0, 1'h0, 1'h1);
    liveStep(1'h1, 1'h1, 1'h0, 1'h0);
    liveStep(1'h1, 1'h0, 1'h0, 1'h1);
    liveStep(1'h1, 1'h0, 1'h1, 1'h0);
    liveStep(1'h0, 1'h0, 1'h0, 1'h0);
    // second reset in mid-run restores the timeout flag
    @(posedge ref_clk);
    rst_b <= 1'h0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'h1;
    expFlags = 20'h10000;
    look();
    endOfTest();
  end
endmodule : sesb_top_bench

`default_nettype wire
